// >>> hdl/pocv_defines.svh
// Register offsets, field positions, reset values and trim width for the loop override and trim control.
// Assumes inclusion by bare name from the design files.
`ifndef POCV_DEFINES_SVH
`define POCV_DEFINES_SVH
`define POCV_ADDR_OVERRIDE     8'h58
`define POCV_ADDR_TRIM         8'h59
`define POCV_ADDR_LOOP_RESET   8'h5c
`define POCV_OVR_EN_BIT        7
`define POCV_SECOND_MODE_HI    5
`define POCV_SECOND_MODE_LO    4
`define POCV_FIRST_MODE_HI     3
`define POCV_FIRST_MODE_LO     2
`define POCV_SE_OVR_BIT        1
`define POCV_EN_OVR_BIT        0
`define POCV_OVERRIDE_RESET    8'h00
`define POCV_TRIM_RESET        7'h00
`define POCV_LOOP_RESET_RESET  1'b0
`define POCV_TRIM_WIDTH        7
`endif

// >>> hdl/pocv_pkg.sv
// Types shared by the loop override and trim control files.
// Assumes nothing beyond a SystemVerilog compiler.
package pocv_pkg;
  typedef logic [1:0] pocv_div_mode_t;
  typedef enum logic [1:0] {
    POCV_DIV_OFF,
    POCV_DIV_BY1,
    POCV_DIV_BY2,
    POCV_DIV_BY4
  } pocv_div_sel_t;
  typedef enum logic [1:0] {
    POCV_CAL_IDLE,
    POCV_CAL_RUN,
    POCV_CAL_DONE
  } pocv_cal_state_t;
endpackage : pocv_pkg

// >>> hdl/pocv_ref_divider.sv
// One divided-reference output: divides the loop reference by 1, 2 or 4, or holds low.
// Assumes ref_clk_in is a synchronous level sampled on sys_clk.
`timescale 1ns/100ps
`default_nettype none
module pocv_ref_divider
  import pocv_pkg::*;
(
  input  wire logic           sys_clk,
  input  wire logic           arst_n,
  input  wire logic           clk_en,
  input  wire pocv_div_sel_t  mode,
  input  wire logic           ref_clk_in,
  output logic                div_out,
  output logic                active
);
  logic       ref_prev_q;
  logic [1:0] cnt_q;
  logic       out_q;

  // Count rising reference edges; output is a registered level
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_prev_q <= 1'b0;
      cnt_q      <= 2'h0;
      out_q      <= 1'b0;
    end else if (clk_en) begin
      ref_prev_q <= ref_clk_in;
      if (mode == POCV_DIV_OFF) begin
        cnt_q <= 2'h0;
        out_q <= 1'b0;
      end else if (mode == POCV_DIV_BY1) begin
        out_q <= ref_clk_in;
      end else if (ref_clk_in && !ref_prev_q) begin
        cnt_q <= cnt_q + 2'h1;
        out_q <= (mode == POCV_DIV_BY2) ? cnt_q[0] == 1'b0 : cnt_q[1] == 1'b0;
      end
    end
  end

  assign div_out = out_q;
  assign active  = (mode != POCV_DIV_OFF);
endmodule : pocv_ref_divider
`default_nettype wire

// >>> hdl/pocv_ctrl.sv
// Loop pin override, oscillator trim and loop reset registers with a calibration sequencer.
// Assumes a byte-wide register port decoded from the serial interface, one access per strobe.
//
// Behaviour
// - Override bit 7 ignores configuration pins
// - Override off: pins drive loop functions
// - Override on: register fields drive functions
// - Bits 5:4 set second output divide
// - Mode fields ignored when override off
// - Second output needs first output running
// - Bits 3:2 set first output divide
// - Bit 1 selects single-ended reference
// - Bit 0 enables loop under override
// - Trim bits 6:0 written by engine/software
// - Calibration starts when reset bit cleared
// - Done reads one when finished or skipped
`timescale 1ns/100ps
`default_nettype none
`include "pocv_defines.svh"
module pocv_ctrl
  import pocv_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        arst_n,
  input  wire logic                        clk_en,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  output logic      [7:0]                  reg_rdata,
  input  wire logic                        loop_enable_pin,
  input  wire logic                        ref_type_select_pin,
  input  wire logic                        clock_config_pin_a,
  input  wire logic                        clock_config_pin_b,
  input  wire logic                        calibration_enable,
  input  wire logic                        cal_engine_wr,
  input  wire logic [`POCV_TRIM_WIDTH-1:0] cal_engine_trim,
  input  wire logic                        cal_engine_finished,
  input  wire logic                        loop_ref_clk,
  output logic                             loop_enable,
  output logic                             single_ended_ref_input_sel,
  output logic                             first_divided_ref_output,
  output logic                             second_divided_ref_output,
  output logic [`POCV_TRIM_WIDTH-1:0]      oscillator_trim,
  output logic                             loop_reset_bit,
  output logic                             cal_engine_start,
  output logic                             calibration_done,
  output logic                             calibration_running
);
  logic [7:0]                  override_q;
  logic [`POCV_TRIM_WIDTH-1:0] trim_q;
  logic                        loop_reset_q;
  pocv_cal_state_t             cal_state_q;
  logic                        start_q;
  logic                        loop_override_enable;
  pocv_div_mode_t              first_divided_ref_mode;
  pocv_div_mode_t              second_divided_ref_mode;
  pocv_div_sel_t               first_sel;
  pocv_div_sel_t               second_sel;
  logic                        first_active;
  logic                        second_raw;
  logic                        wr_ovr;
  logic                        wr_trim;
  logic                        wr_rst;

  assign wr_ovr  = reg_wr && (reg_addr == `POCV_ADDR_OVERRIDE);
  assign wr_trim = reg_wr && (reg_addr == `POCV_ADDR_TRIM);
  assign wr_rst  = reg_wr && (reg_addr == `POCV_ADDR_LOOP_RESET);

  // Override register stores all eight bits; reserved bit kept as written
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      override_q <= `POCV_OVERRIDE_RESET;
    end else if (clk_en && wr_ovr) begin
      override_q <= reg_wdata;
    end
  end

  // Trim register; an engine update during a run wins over a software write in the same cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      trim_q <= `POCV_TRIM_RESET;
    end else if (clk_en) begin
      if (cal_engine_wr && calibration_running) begin
        trim_q <= cal_engine_trim;
      end else if (wr_trim) begin
        trim_q <= reg_wdata[`POCV_TRIM_WIDTH-1:0];
      end
    end
  end

  // Loop reset bit; only bit 0 is stored, upper bits read zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      loop_reset_q <= `POCV_LOOP_RESET_RESET;
    end else if (clk_en && wr_rst) begin
      loop_reset_q <= reg_wdata[0];
    end
  end

  // Calibration sequencer: reset bit high aborts, falling write starts a run
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cal_state_q <= POCV_CAL_IDLE;
      start_q     <= 1'b0;
    end else if (clk_en) begin
      start_q <= 1'b0;
      unique case (cal_state_q)
        POCV_CAL_IDLE: begin
          if (wr_rst && !reg_wdata[0] && loop_reset_q) begin
            if (calibration_enable) begin
              cal_state_q <= POCV_CAL_RUN;
              start_q     <= 1'b1;
            end else begin
              cal_state_q <= POCV_CAL_DONE;
            end
          end
        end
        POCV_CAL_RUN: begin
          if (loop_reset_q) begin
            cal_state_q <= POCV_CAL_IDLE;
          end else if (cal_engine_finished) begin
            cal_state_q <= POCV_CAL_DONE;
          end
        end
        POCV_CAL_DONE: begin
          if (wr_rst && reg_wdata[0]) begin
            cal_state_q <= POCV_CAL_IDLE;
          end
        end
      endcase
    end
  end

  assign calibration_running = (cal_state_q == POCV_CAL_RUN);
  assign calibration_done    = (cal_state_q == POCV_CAL_DONE) || !calibration_enable;
  assign cal_engine_start    = start_q;
  assign loop_reset_bit      = loop_reset_q;

  // Source selection between pins and register fields
  assign loop_override_enable    = override_q[`POCV_OVR_EN_BIT];
  assign first_divided_ref_mode  = override_q[`POCV_FIRST_MODE_HI:`POCV_FIRST_MODE_LO];
  assign second_divided_ref_mode = override_q[`POCV_SECOND_MODE_HI:`POCV_SECOND_MODE_LO];

  always_comb begin
    if (loop_override_enable) begin
      loop_enable                = override_q[`POCV_EN_OVR_BIT];
      single_ended_ref_input_sel = override_q[`POCV_SE_OVR_BIT];
      first_sel                  = pocv_div_sel_t'(first_divided_ref_mode);
      second_sel                 = pocv_div_sel_t'(second_divided_ref_mode);
    end else begin
      // Pin mode: config pins pick divide; mode fields unused
      loop_enable                = loop_enable_pin;
      single_ended_ref_input_sel = ref_type_select_pin;
      first_sel                  = pocv_div_sel_t'({clock_config_pin_b, clock_config_pin_a});
      second_sel                 = pocv_div_sel_t'({clock_config_pin_b, clock_config_pin_a});
    end
  end

  pocv_ref_divider u_first (
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .clk_en     (clk_en),
    .mode       (first_sel),
    .ref_clk_in (loop_ref_clk),
    .div_out    (first_divided_ref_output),
    .active     (first_active)
  );

  // Second divider is held off unless the first is running
  pocv_ref_divider u_second (
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .clk_en     (clk_en),
    .mode       (first_active ? second_sel : POCV_DIV_OFF),
    .ref_clk_in (loop_ref_clk),
    .div_out    (second_raw),
    .active     ()
  );
  assign second_divided_ref_output = second_raw;

  assign oscillator_trim = trim_q;

  // Read mux from flops; unmapped addresses read zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      unique case (reg_addr)
        `POCV_ADDR_OVERRIDE:   reg_rdata <= override_q;
        `POCV_ADDR_TRIM:       reg_rdata <= {1'b0, trim_q};
        `POCV_ADDR_LOOP_RESET: reg_rdata <= {7'h00, loop_reset_q};
        default:               reg_rdata <= 8'h00;
      endcase
    end
  end

  // Checks: calibration sequencing; the start and skip checks are built from the release step
  sequence release_seq;
    wr_rst && !reg_wdata[0] && loop_reset_q && clk_en;
  endsequence

  sequence idle_release_seq;
    release_seq ##0 (cal_state_q == POCV_CAL_IDLE);
  endsequence

  sequence run_seq;
    calibration_running && start_q;
  endsequence

  cal_start_run_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    idle_release_seq ##0 calibration_enable |=> run_seq)
    else $error("calibration did not start on reset release");
  cal_skip_run_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    idle_release_seq ##0 !calibration_enable |=> cal_state_q == POCV_CAL_DONE && !start_q)
    else $error("skipped calibration did not report done");
  start_pulse_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && start_q |=> !start_q)
    else $error("engine start longer than one cycle");
  cal_abort_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && calibration_running && loop_reset_q |=> cal_state_q == POCV_CAL_IDLE)
    else $error("loop reset did not abort calibration");
  cal_finish_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && calibration_running && !loop_reset_q && cal_engine_finished |=> calibration_done)
    else $error("done not set after engine finished");
  cal_skip_done_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !calibration_enable |-> calibration_done)
    else $error("done not set when calibration disabled");

  // Checks: register storage, reset values and the clock-enable freeze
  rst_zero_a: assert property (@(posedge sys_clk)
    !arst_n |-> override_q == `POCV_OVERRIDE_RESET && trim_q == `POCV_TRIM_RESET && !loop_reset_q)
    else $error("registers not cleared by reset");
  freeze_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !clk_en |=> $stable(override_q) && $stable(trim_q) && $stable(loop_reset_q) && $stable(cal_state_q))
    else $error("state changed while clock enable low");
  ovr_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && wr_ovr |=> override_q == $past(reg_wdata))
    else $error("override write lost");
  loop_rst_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && wr_rst |=> loop_reset_q == $past(reg_wdata[0]))
    else $error("loop reset write lost");
  trim_sw_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && wr_trim && !(cal_engine_wr && calibration_running) |=> trim_q == $past(reg_wdata[6:0]))
    else $error("trim write lost");
  trim_engine_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && cal_engine_wr && calibration_running |=> trim_q == $past(cal_engine_trim))
    else $error("engine trim not stored");
  trim_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !wr_trim && !(cal_engine_wr && calibration_running) |=> $stable(trim_q))
    else $error("trim changed without an accepted write");
  rd_trim_top_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && reg_rd && reg_addr == `POCV_ADDR_TRIM |=> !reg_rdata[7])
    else $error("trim top bit read nonzero");
  rd_rst_upper_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && reg_rd && reg_addr == `POCV_ADDR_LOOP_RESET |=> reg_rdata[7:1] == 7'h00)
    else $error("loop reset upper bits read nonzero");

  // Checks: source selection and divided outputs
  ovr_loop_en_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    override_q[7] |-> loop_enable == override_q[0])
    else $error("loop enable not from register under override");
  pin_loop_en_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !override_q[7] |-> loop_enable == loop_enable_pin && single_ended_ref_input_sel == ref_type_select_pin)
    else $error("pin mode not followed");
  ovr_se_sel_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    override_q[7] |-> single_ended_ref_input_sel == override_q[1])
    else $error("ref select not from register under override");
  ovr_first_mode_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    override_q[7] |-> first_sel == pocv_div_sel_t'(override_q[3:2]) && second_sel == pocv_div_sel_t'(override_q[5:4]))
    else $error("divided modes not from register");
  pin_div_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !override_q[7] |-> first_sel == pocv_div_sel_t'({clock_config_pin_b, clock_config_pin_a}) && second_sel == first_sel)
    else $error("divided modes not from pins");
  second_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && first_sel == POCV_DIV_OFF |=> !second_divided_ref_output)
    else $error("second output runs without first");
  first_off_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && first_sel == POCV_DIV_OFF |=> !first_divided_ref_output)
    else $error("first output runs while disabled");
  first_by1_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && first_sel == POCV_DIV_BY1 |=> first_divided_ref_output == $past(loop_ref_clk))
    else $error("first output not following reference");
  second_by1_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clk_en && first_sel != POCV_DIV_OFF && second_sel == POCV_DIV_BY1 |=> second_divided_ref_output == $past(loop_ref_clk))
    else $error("second output not following reference");
endmodule : pocv_ctrl
`default_nettype wire

// >>> tb/pocv_ctrl_test.sv
// Self-checking bench for the loop override, trim and loop reset control.
// Assumes the design files under hdl/ are compiled first; inputs change on falling edges.
`timescale 1ns/100ps
`default_nettype none
`include "pocv_defines.svh"
module pocv_ctrl_test;
  import pocv_pkg::*;
  logic       sys_clk, arst_n, clk_en, reg_wr, reg_rd, cal_en, eng_wr, eng_fin, ref_clk, ref_run;
  logic [7:0] addr, wdata, rdata, rd_val;
  logic       en_pin, sel_pin, pin_a, pin_b, loop_en, se_sel, first_out, second_out, loop_rst, start, done, running;
  logic [6:0] eng_trim, trim;
  logic       f_prev, s_prev;
  int         n_f, n_s, n_mismatch, checked;

  pocv_ctrl dut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .loop_enable_pin(en_pin),
    .ref_type_select_pin(sel_pin), .clock_config_pin_a(pin_a), .clock_config_pin_b(pin_b),
    .calibration_enable(cal_en), .cal_engine_wr(eng_wr), .cal_engine_trim(eng_trim),
    .cal_engine_finished(eng_fin), .loop_ref_clk(ref_clk), .loop_enable(loop_en),
    .single_ended_ref_input_sel(se_sel), .first_divided_ref_output(first_out),
    .second_divided_ref_output(second_out), .oscillator_trim(trim), .loop_reset_bit(loop_rst),
    .cal_engine_start(start), .calibration_done(done), .calibration_running(running));

  // Clock at 100 ns period
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Reference toggles every cycle, so a divide by 1 gives 32 rises in 64 cycles
  always @(negedge sys_clk) if (ref_run) ref_clk <= ~ref_clk;

  // Rise counters on both divided outputs; sampled mid-cycle, clear of the launching edge
  always @(negedge sys_clk) begin
    f_prev <= first_out;
    s_prev <= second_out;
    if (first_out === 1'b1 && f_prev === 1'b0) n_f++;
    if (second_out === 1'b1 && s_prev === 1'b0) n_s++;
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1; addr = a; wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk);
    reg_rd = 1'b1; addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    rd_val = rdata;
  endtask : rd

  // Counts rises over 64 cycles after a short settle; expected is within one
  task automatic rate(input int mf, input int ms);
    int ef, es;
    ef = (mf == 0) ? 0 : 64 >> mf;
    es = (ms == 0) ? 0 : 64 >> ms;
    repeat (8) @(negedge sys_clk);
    // Window opens and closes on rising edges so it never races the counters
    @(posedge sys_clk);
    n_f = 0; n_s = 0;
    repeat (64) @(posedge sys_clk);
    chk("first_rate", 8'(n_f >= ef - 1 && n_f <= ef + 1), 8'h01);
    chk("second_rate", 8'(n_s >= es - 1 && n_s <= es + 1), 8'h01);
    @(negedge sys_clk);
  endtask : rate

  task automatic t_reset;
    rd(`POCV_ADDR_OVERRIDE); chk("override_rst", rd_val, 8'h00);
    rd(`POCV_ADDR_TRIM); chk("trim_rst", rd_val, 8'h00);
    rd(`POCV_ADDR_LOOP_RESET); chk("loop_rst_rst", rd_val, 8'h00);
    rd(8'h5a); chk("unmapped", rd_val, 8'h00);
  endtask : t_reset

  // Mode fields written but override off: pins still rule
  task automatic t_pins;
    wr(`POCV_ADDR_OVERRIDE, 8'h3c);
    en_pin = 1'b1; sel_pin = 1'b1;
    @(negedge sys_clk);
    chk("pin_enable", 8'(loop_en), 8'h01);
    chk("pin_select", 8'(se_sel), 8'h01);
    for (int m = 0; m < 4; m++) begin
      {pin_b, pin_a} = 2'(m);
      rate(m, m);
    end
  endtask : t_pins

  task automatic t_override;
    wr(`POCV_ADDR_OVERRIDE, 8'h80);
    chk("ovr_en_off", 8'(loop_en), 8'h00);
    chk("ovr_se_off", 8'(se_sel), 8'h00);
    wr(`POCV_ADDR_OVERRIDE, 8'h83);
    chk("ovr_en_on", 8'(loop_en), 8'h01);
    chk("ovr_se_on", 8'(se_sel), 8'h01);
    rd(`POCV_ADDR_OVERRIDE); chk("ovr_read", rd_val, 8'h83);
    {pin_b, pin_a} = 2'b00;
    for (int m = 0; m < 4; m++) begin
      wr(`POCV_ADDR_OVERRIDE, 8'h81 | 8'(m << 2) | 8'(m << 4));
      rate(m, m);
    end
    wr(`POCV_ADDR_OVERRIDE, 8'h91);
    rate(0, 0);
    wr(`POCV_ADDR_OVERRIDE, 8'hb5);
    rate(1, 3);
  endtask : t_override

  task automatic t_trim;
    wr(`POCV_ADDR_TRIM, 8'h7f);
    chk("trim_port", 8'(trim), 8'h7f);
    rd(`POCV_ADDR_TRIM); chk("trim_read", rd_val, 8'h7f);
  endtask : t_trim

  task automatic t_cal;
    int k;
    cal_en = 1'b1;
    wr(`POCV_ADDR_LOOP_RESET, 8'h01);
    rd(`POCV_ADDR_LOOP_RESET); chk("loop_rst_set", rd_val, 8'h01);
    chk("loop_rst_port", 8'(loop_rst), 8'h01);
    wr(`POCV_ADDR_LOOP_RESET, 8'h00);
    chk("cal_start", 8'(start), 8'h01);
    chk("cal_running", 8'(running), 8'h01);
    chk("cal_busy", 8'(done), 8'h00);
    // Engine writes trim 2a while the run is active
    eng_wr = 1'b1; eng_trim = 7'h2a;
    @(negedge sys_clk);
    chk("start_pulse", 8'(start), 8'h00);
    eng_wr = 1'b0; eng_fin = 1'b1;
    k = 0;
    while (done !== 1'b1 && k < 10) begin
      @(negedge sys_clk);
      k++;
    end
    chk("cal_done", 8'(k < 10), 8'h01);
    eng_fin = 1'b0;
    if (k >= 10) return;
    rd(`POCV_ADDR_TRIM); chk("cal_trim", rd_val, 8'h2a);
    // Engine writes outside a run are refused
    eng_wr = 1'b1; eng_trim = 7'h15;
    @(negedge sys_clk);
    eng_wr = 1'b0;
    rd(`POCV_ADDR_TRIM); chk("eng_refused", rd_val, 8'h2a);
    // Setting the reset bit mid-run aborts the run
    wr(`POCV_ADDR_LOOP_RESET, 8'h01);
    wr(`POCV_ADDR_LOOP_RESET, 8'h00);
    chk("rerun", 8'(running), 8'h01);
    wr(`POCV_ADDR_LOOP_RESET, 8'h01);
    @(negedge sys_clk);
    chk("abort_run", 8'(running), 8'h00);
    chk("abort_done", 8'(done), 8'h00);
    // Release with calibration disabled skips straight to done
    cal_en = 1'b0;
    wr(`POCV_ADDR_LOOP_RESET, 8'h00);
    chk("skip_nostart", 8'(start), 8'h00);
    chk("cal_skipped", 8'(done), 8'h01);
  endtask : t_cal

  // Enable low freezes registers; a second reset after calibration is done clears them
  task automatic t_freeze;
    en_pin = 1'b0;
    wr(`POCV_ADDR_OVERRIDE, 8'h81);
    clk_en = 1'b0;
    wr(`POCV_ADDR_OVERRIDE, 8'h03);
    clk_en = 1'b1;
    chk("freeze_en", 8'(loop_en), 8'h01);
    rd(`POCV_ADDR_OVERRIDE); chk("freeze_ovr", rd_val, 8'h81);
    arst_n = 1'b0;
    @(negedge sys_clk);
    arst_n = 1'b1;
    chk("rerst_en", 8'(loop_en), 8'h00);
    rd(`POCV_ADDR_OVERRIDE); chk("rerst_ovr", rd_val, 8'h00);
    rd(`POCV_ADDR_TRIM); chk("rerst_trim", rd_val, 8'h00);
  endtask : t_freeze

  task automatic end_of_test;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // Main sequence; reset held for 12 cycles
  initial begin
    arst_n = 1'b0; clk_en = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; addr = 8'h00; wdata = 8'h00;
    en_pin = 1'b0; sel_pin = 1'b0; pin_a = 1'b0; pin_b = 1'b0; cal_en = 1'b0; eng_wr = 1'b0;
    eng_trim = 7'h00; eng_fin = 1'b0; ref_clk = 1'b0; ref_run = 1'b1; n_mismatch = 0; checked = 0;
    repeat (12) @(negedge sys_clk);
    arst_n = 1'b1;
    t_reset();
    t_pins();
    t_override();
    t_trim();
    t_cal();
    t_freeze();
    end_of_test();
  end
endmodule : pocv_ctrl_test
`default_nettype wire
